// ==== include/iwbm_pkg.sv ====
// Constants, types and carriers shared by the indexed word and bit mover.
//
// Behaviour
// - With the run and condition bits at 1 the operation repeats on every scan.
// - With the condition bit at 0 no operation writes data or flags.
// - Distribution writes the source word to base channel plus offset value.
// - A distributed word of zero sets the zero flag at aux bit 6306.
// - Extraction reads base plus offset and writes it to the destination.
// - An extracted word of zero sets the flag at aux bit 6303.
// - Non-BCD offset or target outside the base area sets 6303 and skips.
// - Indirect pointers are taken only from data memory channels 000 to 511.
// - Pointer contents non-BCD or beyond 511 set 6303 and skip the operation.
// - Offsets are bounded by one of five areas: I/O, link, holding, timer, DM.
// - Special aux channels are no distribution target but extraction may read them.
// - Largest offset is the distance from base to the last channel of its area.
// - Bit copy moves one source bit to one destination bit, others kept.
// - Bit copy control gives both bit numbers in BCD, legal from 0 to 15.
// - Bad bit copy control sets 6303 and leaves the destination unchanged.
// - Distribution operands outside their area ranges set the error flag and skip.
package iwbm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_TIME_NS = 1000;
  localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
  localparam int SCAN_CNT_W = 8;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CTRL = 16'h0000;
  localparam logic [15:0] ADDR_OPCODE = 16'h0004;
  localparam logic [15:0] ADDR_OPA = 16'h0008;
  localparam logic [15:0] ADDR_OPB = 16'h000C;
  localparam logic [15:0] ADDR_OPC = 16'h0010;
  localparam logic [15:0] ADDR_STATUS = 16'h0014;
  localparam logic [15:0] ADDR_MASK = 16'h0018;
  localparam logic [15:0] ADDR_RESULT = 16'h001C;
  localparam logic [3:0] MEM_WIN_PAGE = 4'h1;
  localparam int CH_COUNT = 768;
  localparam int CTRL_COND = 0;
  localparam int CTRL_RUN = 1;
  localparam int CTRL_START = 2;
  localparam int ST_DONE = 0;
  localparam int ST_ERR = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_W = 3;

  // ----------------------------------------------------------------
  // Operand word layout and channel areas
  // ----------------------------------------------------------------
  localparam int OPD_IND_BIT = 31;
  localparam int OPD_AREA_LSB = 28;
  localparam int OPD_NUM_LSB = 16;
  localparam logic [2:0] AREA_IO = 3'h0;
  localparam logic [2:0] AREA_LINK = 3'h1;
  localparam logic [2:0] AREA_HOLD = 3'h2;
  localparam logic [2:0] AREA_TC = 3'h3;
  localparam logic [2:0] AREA_DM = 3'h4;
  localparam logic [2:0] AREA_CONST = 3'h5;
  localparam logic [9:0] BASE_IO = 10'h000;
  localparam logic [9:0] BASE_LINK = 10'h040;
  localparam logic [9:0] BASE_HOLD = 10'h060;
  localparam logic [9:0] BASE_TC = 10'h080;
  localparam logic [9:0] BASE_DM = 10'h100;
  localparam logic [9:0] MAX_IO_SRC = 10'h03F;
  localparam logic [9:0] MAX_IO_DST = 10'h03C;
  localparam logic [9:0] MAX_LINK = 10'h01F;
  localparam logic [9:0] MAX_HOLD = 10'h01F;
  localparam logic [9:0] MAX_TC = 10'h07F;
  localparam logic [9:0] MAX_DM = 10'h1FF;
  localparam logic [9:0] AUX_FLAG_CH = 10'h03F;
  localparam int FLAG_ERR_BIT = 3;
  localparam int FLAG_ZERO_BIT = 6;
  localparam logic [13:0] BIT_NUM_MAX = 14'h000F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WORD_DISTRIBUTE_OP, WORD_EXTRACT_OP, BIT_COPY_OP} iwbm_op_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } iwbm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } iwbm_apb_rsp_t;

  typedef struct packed {
    logic ok;
    logic [2:0] area;
    logic [9:0] ch;
    logic [9:0] gaddr;
    logic [15:0] value;
  } iwbm_opnd_t;

  typedef struct packed {
    logic cond;
    logic run;
    logic pend;
    logic [1:0] op;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opc;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic flag_err;
    logic flag_zero;
    logic [SCAN_CNT_W-1:0] scan_cnt;
    logic [15:0] result;
    logic [31:0] prdata;
  } iwbm_state_t;

endpackage

// ==== verilog/iwbm_top.sv ====
// Indexed word distribute, word extract and bit copy engine with APB access.
`timescale 1ns/1ps

module iwbm_top (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire iwbm_pkg::iwbm_apb_req_t I_APB,
  output iwbm_pkg::iwbm_apb_rsp_t O_APB,
  output logic O_IRQ,
  output logic O_ERROR_FLAG,
  output logic O_ZERO_FLAG
);
  import iwbm_pkg::*;

  // ----------------------------------------------------------------
  // Storage and helpers
  // ----------------------------------------------------------------
  iwbm_state_t r;
  iwbm_state_t next_r;
  logic [15:0] mem [CH_COUNT];

  // Every nibble of a word must be a decimal digit.
  function automatic logic is_bcd(input logic [15:0] w);
    return (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) && (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
  endfunction

  // Converts a four-digit BCD word into binary.
  function automatic logic [13:0] bcd_bin(input logic [15:0] w);
    return 14'(w[15:12]) * 14'd1000 + 14'(w[11:8]) * 14'd100 + 14'(w[7:4]) * 14'd10
      + 14'(w[3:0]);
  endfunction

  // Reads a channel; the flag channel shows the live flag bits.
  function automatic logic [15:0] rd_word(input logic [9:0] ga);
    logic [15:0] w;
    w = mem[ga];
    if (ga == AUX_FLAG_CH)
    begin
      w[FLAG_ERR_BIT] = r.flag_err;
      w[FLAG_ZERO_BIT] = r.flag_zero;
    end
    return w;
  endfunction

  // First global channel of an area.
  function automatic logic [9:0] area_base(input logic [2:0] area);
    case (area)
      AREA_LINK: return BASE_LINK;
      AREA_HOLD: return BASE_HOLD;
      AREA_TC: return BASE_TC;
      AREA_DM: return BASE_DM;
      default: return BASE_IO;
    endcase
  endfunction

  // Legality and last channel of an area; bit 10 flags a legal area.
  function automatic logic [10:0] area_lim(input logic [2:0] area, input logic [9:0] io_max,
                                           input logic allow_tc);
    case (area)
      AREA_IO: return {1'b1, io_max};
      AREA_LINK: return {1'b1, MAX_LINK};
      AREA_HOLD: return {1'b1, MAX_HOLD};
      AREA_TC: return {allow_tc, MAX_TC};
      AREA_DM: return {1'b1, MAX_DM};
      default: return 11'h000;
    endcase
  endfunction

  // Resolves an operand word into area, channel and value, with checks.
  function automatic iwbm_opnd_t resolve(input logic [31:0] op, input logic [9:0] io_max,
                                         input logic allow_const, input logic allow_tc);
    iwbm_opnd_t o;
    logic [10:0] lim;
    logic [15:0] ptr;
    logic [13:0] pbin;
    logic [9:0] num;
    o = '0;
    num = op[OPD_NUM_LSB +: 10];
    o.area = op[OPD_AREA_LSB +: 3];
    lim = area_lim(o.area, io_max, allow_tc);
    ptr = (num <= MAX_DM) ? rd_word(BASE_DM + num) : 16'h0000;
    pbin = bcd_bin(ptr);
    if (op[OPD_IND_BIT])
    begin
      // Pointers live only in data memory and must name a data memory channel.
      o.area = AREA_DM;
      o.ch = pbin[9:0];
      o.ok = (num <= MAX_DM) && is_bcd(ptr) && (pbin <= 14'(MAX_DM));
    end
    else if (o.area == AREA_CONST)
    begin
      o.ok = allow_const;
      o.value = op[15:0];
    end
    else
    begin
      o.ch = num;
      o.ok = lim[10] && (num <= lim[9:0]);
    end
    o.gaddr = o.ok ? area_base(o.area) + o.ch : 10'h000;
    if (o.ok && (o.area != AREA_CONST))
    begin
      o.value = rd_word(o.gaddr);
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic [9:0] idx;
  logic in_mem;
  logic in_reg;
  logic [31:0] rd_mux;

  // Registers sit in the first 32 bytes, channels in a window one word each.
  always_comb
  begin
    apb_acc = I_APB.psel && I_APB.penable;
    apb_wr = apb_acc && I_APB.pwrite;
    apb_rd = apb_acc && !I_APB.pwrite;
    idx = I_APB.paddr[11:2];
    in_mem = (I_APB.paddr[15:12] == MEM_WIN_PAGE) && (idx < 10'(CH_COUNT))
      && (I_APB.paddr[1:0] == 2'h0);
    in_reg = (I_APB.paddr[15:5] == 11'h000) && (I_APB.paddr[1:0] == 2'h0);
    rd_mux = 32'h0000_0000;
    if (in_mem)
    begin
      rd_mux = {16'h0000, rd_word(idx)};
    end
    else
    begin
      case (I_APB.paddr)
        ADDR_CTRL: rd_mux = {30'h0000_0000, r.run, r.cond};
        ADDR_OPCODE: rd_mux = {30'h0000_0000, r.op};
        ADDR_OPA: rd_mux = r.opa;
        ADDR_OPB: rd_mux = r.opb;
        ADDR_OPC: rd_mux = r.opc;
        ADDR_STATUS: rd_mux = {29'h0000_0000, r.status};
        ADDR_MASK: rd_mux = {29'h0000_0000, r.mask};
        ADDR_RESULT: rd_mux = {16'h0000, r.result};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operation datapath
  // ----------------------------------------------------------------
  iwbm_opnd_t oa;
  iwbm_opnd_t ob;
  iwbm_opnd_t oc;
  logic fire;
  logic exec;
  logic ex_err;
  logic ex_we;
  logic ex_zero;
  logic [9:0] ex_addr;
  logic [15:0] ex_data;
  logic [13:0] tgt;
  logic [10:0] lim;
  logic [13:0] sbit;
  logic [13:0] dbit;
  logic [15:0] bit_mask;
  logic src_bit;

  // A pending operation waits out any bus write so memory has one writer.
  always_comb
  begin
    fire = r.pend && !apb_wr;
    exec = fire && r.cond;
    oa = '0;
    ob = '0;
    oc = '0;
    tgt = 14'h0000;
    lim = 11'h000;
    sbit = 14'h0000;
    dbit = 14'h0000;
    bit_mask = 16'h0000;
    src_bit = 1'b0;
    ex_err = 1'b1;
    ex_addr = 10'h000;
    ex_data = 16'h0000;
    unique case (iwbm_op_t'(r.op))
      WORD_DISTRIBUTE_OP:
      begin
        // Special aux channels are excluded from the target area.
        oa = resolve(r.opa, MAX_IO_SRC, 1'b1, 1'b1);
        ob = resolve(r.opb, MAX_IO_DST, 1'b0, 1'b1);
        oc = resolve(r.opc, MAX_IO_DST, 1'b0, 1'b1);
        tgt = 14'(ob.ch) + bcd_bin(oc.value);
        lim = area_lim(ob.area, MAX_IO_DST, 1'b1);
        ex_err = !(oa.ok && ob.ok && oc.ok && is_bcd(oc.value) && (tgt <= 14'(lim[9:0])));
        ex_addr = area_base(ob.area) + tgt[9:0];
        ex_data = oa.value;
      end
      WORD_EXTRACT_OP:
      begin
        // The base may sit in the special aux part of the I/O area.
        oa = resolve(r.opa, MAX_IO_SRC, 1'b0, 1'b1);
        ob = resolve(r.opb, MAX_IO_SRC, 1'b0, 1'b1);
        oc = resolve(r.opc, MAX_IO_DST, 1'b0, 1'b1);
        tgt = 14'(oa.ch) + bcd_bin(ob.value);
        lim = area_lim(oa.area, MAX_IO_SRC, 1'b1);
        ex_err = !(oa.ok && ob.ok && oc.ok && is_bcd(ob.value) && (tgt <= 14'(lim[9:0])));
        ex_addr = oc.gaddr;
        ex_data = ex_err ? 16'h0000 : rd_word(area_base(oa.area) + tgt[9:0]);
      end
      BIT_COPY_OP:
      begin
        oa = resolve(r.opa, MAX_IO_SRC, 1'b1, 1'b0);
        ob = resolve(r.opb, MAX_IO_SRC, 1'b1, 1'b1);
        oc = resolve(r.opc, MAX_IO_DST, 1'b0, 1'b0);
        sbit = bcd_bin({8'h00, ob.value[7:0]});
        dbit = bcd_bin({8'h00, ob.value[15:8]});
        ex_err = !(oa.ok && ob.ok && oc.ok && is_bcd(ob.value)
          && (sbit <= BIT_NUM_MAX) && (dbit <= BIT_NUM_MAX));
        bit_mask = 16'h0001 << dbit[3:0];
        src_bit = oa.value[sbit[3:0]];
        ex_addr = oc.gaddr;
        ex_data = src_bit ? (oc.value | bit_mask) : (oc.value & ~bit_mask);
      end
      default:
      begin
        ex_err = 1'b1;
      end
    endcase
    ex_we = exec && !ex_err;
    ex_zero = (ex_data == 16'h0000);
  end

  // Channel memory: the engine or the bus writes, never both in one cycle.
  always_ff @(posedge I_CLK)
  begin
    if (ex_we)
    begin
      mem[ex_addr] <= ex_data;
    end
    else if (apb_wr && in_mem)
    begin
      mem[idx] <= I_APB.pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic scan_tick;

  // Scan divider, register writes, sticky status and the two flags.
  always_comb
  begin
    next_r = r;
    scan_tick = (r.scan_cnt == SCAN_CNT_W'(SCAN_CYCLES - 1));
    next_r.scan_cnt = scan_tick ? '0 : r.scan_cnt + 1'b1;
    if (fire)
    begin
      next_r.pend = 1'b0;
    end
    if (scan_tick && r.run)
    begin
      next_r.pend = 1'b1;
    end
    if (I_APB.psel && !I_APB.penable)
    begin
      next_r.prdata = rd_mux;
    end
    if (apb_rd && (I_APB.paddr == ADDR_STATUS))
    begin
      next_r.status = '0;
    end
    if (apb_wr && in_reg)
    begin
      case (I_APB.paddr)
        ADDR_CTRL:
        begin
          next_r.cond = I_APB.pwdata[CTRL_COND];
          next_r.run = I_APB.pwdata[CTRL_RUN];
          next_r.pend = next_r.pend || I_APB.pwdata[CTRL_START];
        end
        ADDR_OPCODE: next_r.op = I_APB.pwdata[1:0];
        ADDR_OPA: next_r.opa = I_APB.pwdata;
        ADDR_OPB: next_r.opb = I_APB.pwdata;
        ADDR_OPC: next_r.opc = I_APB.pwdata;
        ADDR_MASK: next_r.mask = I_APB.pwdata[ST_W-1:0];
        default: next_r.mask = r.mask;
      endcase
    end
    if (apb_wr && in_mem && (idx == AUX_FLAG_CH))
    begin
      next_r.flag_err = I_APB.pwdata[FLAG_ERR_BIT];
      next_r.flag_zero = I_APB.pwdata[FLAG_ZERO_BIT];
    end
    // Events set after any clear so that a coinciding set wins.
    if (exec)
    begin
      next_r.status[ST_DONE] = 1'b1;
      if (ex_err)
      begin
        next_r.status[ST_ERR] = 1'b1;
        next_r.flag_err = 1'b1;
      end
      else
      begin
        next_r.result = ex_data;
        if (ex_zero)
        begin
          next_r.status[ST_ZERO] = 1'b1;
        end
        if (ex_zero && (r.op == 2'(WORD_DISTRIBUTE_OP)))
        begin
          next_r.flag_zero = 1'b1;
        end
        if (ex_zero && (r.op == 2'(WORD_EXTRACT_OP)))
        begin
          next_r.flag_err = 1'b1;
        end
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs: zero-wait bus answer, level interrupt and live flags.
  always_comb
  begin
    O_APB.prdata = r.prdata;
    O_APB.pready = 1'b1;
    O_APB.pslverr = apb_acc && !(in_mem || in_reg);
    O_IRQ = |(r.status & r.mask);
    O_ERROR_FLAG = r.flag_err;
    O_ZERO_FLAG = r.flag_zero;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);

  // Each scan raises a request that is consumed within a bus access.
  property p_scan_repeat;
    (r.run && scan_tick) |=> (r.pend ##[1:3] !r.pend);
  endproperty
  a_scan_repeat: assert property (p_scan_repeat) else $error("Scan did not execute.");

  property p_cond_low;
    (fire && !r.cond) |=> ($stable(r.flag_err) && $stable(r.flag_zero) && $stable(r.result));
  endproperty
  a_cond_low: assert property (p_cond_low) else $error("Disabled operation changed state.");

  property p_dist_write;
    (ex_we && (r.op == 2'(WORD_DISTRIBUTE_OP)))
      |=> (mem[$past(ex_addr)] == $past(oa.value));
  endproperty
  a_dist_write: assert property (p_dist_write) else $error("Distributed word missing.");

  property p_dist_zero;
    (ex_we && ex_zero && (r.op == 2'(WORD_DISTRIBUTE_OP))) |=> (O_ZERO_FLAG && r.status[ST_ZERO]);
  endproperty
  a_dist_zero: assert property (p_dist_zero) else $error("Zero flag not set.");

  property p_extr_zero;
    (ex_we && ex_zero && (r.op == 2'(WORD_EXTRACT_OP))) |=> O_ERROR_FLAG;
  endproperty
  a_extr_zero: assert property (p_extr_zero) else $error("Extract zero flag not set.");

  property p_err_skip;
    (exec && ex_err) |-> (!ex_we ##1 (O_ERROR_FLAG && r.status[ST_ERR]));
  endproperty
  a_err_skip: assert property (p_err_skip) else $error("Error did not skip and flag.");

  property p_ind_range;
    (exec && r.opa[OPD_IND_BIT] && (r.opa[OPD_NUM_LSB +: 10] > MAX_DM)) |-> ex_err;
  endproperty
  a_ind_range: assert property (p_ind_range) else $error("Pointer outside DM accepted.");

  property p_bit_keep;
    (ex_we && (r.op == 2'(BIT_COPY_OP)))
      |=> ((((mem[$past(ex_addr)] ^ $past(oc.value)) & ~$past(bit_mask)) == 16'h0000)
      && (((mem[$past(ex_addr)] & $past(bit_mask)) != 16'h0000) == $past(src_bit)));
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("Bit copy disturbed the word.");

  property p_bit_range;
    (exec && (r.op == 2'(BIT_COPY_OP)) && (dbit > BIT_NUM_MAX)) |-> (ex_err && !ex_we);
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("Bad bit number accepted.");

  c_dist_ok: cover property (ex_we && (r.op == 2'(WORD_DISTRIBUTE_OP)));
  c_extr_zero: cover property (ex_we && ex_zero && (r.op == 2'(WORD_EXTRACT_OP)));
  c_bit_copy: cover property (ex_we && (r.op == 2'(BIT_COPY_OP)));
  c_error: cover property (exec && ex_err ##1 O_IRQ);

endmodule // iwbm_top

// ==== verif/iwbm_prog_model.sv ====
// User program model that drives the APB port of the mover.
`timescale 1ns/1ps
module iwbm_prog_model (
  input wire logic i_clk,
  input wire iwbm_pkg::iwbm_apb_rsp_t i_rsp,
  output iwbm_pkg::iwbm_apb_req_t o_req
);
  import iwbm_pkg::*;
  logic [31:0] rdata;
  logic err;
  // The bus starts idle.
  initial o_req = '0;
  // One transfer that stands until pready is seen; released lines show scrambled values.
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge i_clk);
    o_req.penable <= 1'b1;
    do
      @(posedge i_clk);
    while (i_rsp.pready !== 1'b1);
    rdata = i_rsp.prdata;
    err = i_rsp.pslverr;
    o_req <= '{1'b0, 1'b0, !wr, ~a, ~d};
  endtask
endmodule // iwbm_prog_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the indexed word and bit mover.
`timescale 1ns/1ps
module tb_top;
  import iwbm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  iwbm_apb_req_t req;
  iwbm_apb_rsp_t rsp;
  logic irq;
  logic eflag;
  logic zflag;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int lw;
  logic [31:0] seed = 32'h2D974FA0;
  logic [15:0] rm [0:767];
  int lo [0:5] = '{0, 64, 96, 128, 256, 0};
  int hi [0:5] = '{63, 95, 127, 255, 767, 0};

  // Design and the program model on its bus.
  iwbm_top DUT (.I_CLK(clk), .I_RESET(rst), .I_APB(req), .O_APB(rsp), .O_IRQ(irq),
    .O_ERROR_FLAG(eflag), .O_ZERO_FLAG(zflag));
  iwbm_prog_model pm (.i_clk(clk), .i_rsp(rsp), .o_req(req));

  // Clock, and a cycle ceiling that cuts a hang short.
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Reference model of channels and flags
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] opd(int ind, int ar, int ch);
    return {ind[0], ar[2:0], 2'b00, ch[9:0], 16'h0};
  endfunction
  function automatic logic [31:0] cst(int k);
    return {4'h5, 12'h0, k[15:0]};
  endfunction
  function automatic logic isbcd(logic [15:0] v);
    return v[3:0] < 10 && v[7:4] < 10 && v[11:8] < 10 && v[15:12] < 10;
  endfunction
  function automatic int bcd(logic [15:0] v);
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction
  // Global channel of an operand; a bad pointer gives -1.
  function automatic int gch(logic [31:0] w, output int ar);
    logic [15:0] p;
    ar = w[31] ? 4 : int'(w[30:28]);
    if (!w[31])
      return lo[ar] + int'(w[25:16]);
    if (int'(w[25:16]) > 511)
      return -1;
    p = rm[256 + int'(w[25:16])];
    return (isbcd(p) && bcd(p) <= 511) ? 256 + bcd(p) : -1;
  endfunction
  function automatic logic [15:0] val(logic [31:0] w, output logic bad);
    int ar;
    int g;
    g = gch(w, ar);
    bad = g < 0;
    return (!w[31] && ar == 5) ? w[15:0] : (g < 0 ? 16'h0 : rm[g]);
  endfunction
  // Applies one operation to the reference channels.
  task automatic model(logic [1:0] code, logic [31:0] a, logic [31:0] b, logic [31:0] c);
    int ar;
    int ad;
    int g;
    int t;
    int d;
    int s;
    int n;
    logic b1;
    logic b2;
    logic e;
    logic [15:0] v;
    logic [15:0] k;
    lw = -1;
    e = 1'b1;
    case (code)
      2'd0:
      begin
        v = val(a, b1);
        k = val(c, b2);
        g = gch(b, ar);
        d = g + bcd(k);
        e = b1 | b2 | g < 0 | ar == 5 | !isbcd(k) | d > (ar == 0 ? 60 : hi[ar]);
      end
      2'd1:
      begin
        k = val(b, b2);
        g = gch(a, ar);
        t = g + bcd(k);
        d = gch(c, ad);
        e = b2 | g < 0 | d < 0 | ar == 5 | ad == 5 | !isbcd(k) | t > hi[ar] | (ad == 0 && d > 60);
        v = e ? 16'h0 : rm[t];
      end
      2'd2:
      begin
        v = val(a, b1);
        k = val(b, b2);
        d = gch(c, ad);
        s = bcd({8'h0, k[7:0]});
        n = bcd({8'h0, k[15:8]});
        e = b1 | b2 | d < 0 | ad == 5 | (ad == 0 && d > 60) | !isbcd(k) | s > 15 | n > 15
          | ad == 3 | (a[30:28] == 3'd3 && !a[31]);
      end
      default: e = 1'b1;
    endcase
    if (e)
      rm[63][3] = 1'b1;
    else
    begin
      if (code == 2'd2)
        rm[d][n] = v[s];
      else
        rm[d] = v;
      lw = d;
      if (code != 2'd2 && v == 16'h0)
        rm[63][code == 2'd0 ? 6 : 3] = 1'b1;
    end
  endtask

  // ----------------------------------------------------------------
  // Bus helpers and comparisons
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] cha(int i);
    return {MEM_WIN_PAGE, 12'h000} + 16'(i * 4);
  endfunction
  task automatic wch(int i, logic [15:0] x);
    pm.xfer(1'b1, cha(i), {16'h0, x});
    rm[i] = x;
  endtask
  task automatic chkch(int i);
    pm.xfer(1'b0, cha(i), 32'h0);
    chk("channel", {16'h0, rm[i]}, pm.rdata);
  endtask
  // Loads an operation, requests it, then compares written and watched channels and flags.
  task automatic op(logic [1:0] code, logic [31:0] a, logic [31:0] b, logic [31:0] c, int w,
    logic [31:0] cv);
    pm.xfer(1'b1, ADDR_OPCODE, {30'h0, code});
    pm.xfer(1'b1, ADDR_OPA, a);
    pm.xfer(1'b1, ADDR_OPB, b);
    pm.xfer(1'b1, ADDR_OPC, c);
    pm.xfer(1'b1, ADDR_CTRL, cv);
    repeat (3) @(posedge clk);
    lw = -1;
    if (cv[CTRL_COND])
      model(code, a, b, c);
    if (lw >= 0)
      chkch(lw);
    chkch(w);
    chk("error flag", {31'h0, rm[63][3]}, {31'h0, eflag});
    chk("zero flag", {31'h0, rm[63][6]}, {31'h0, zflag});
  endtask
  task automatic wrap_up();
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    logic [15:0] v;
    int s;
    int d;
    logic [31:0] oc;
    logic [31:0] dc;
    static logic [15:0] bad [0:2] = '{16'h0016, 16'h1600, 16'h000A};
    oc = opd(0, 4, 500);
    dc = opd(0, 4, 30);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pm.xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0, pm.rdata);
    chk("irq", 32'h0, {31'h0, irq});
    pm.xfer(1'b0, 16'h0020, 32'h0);
    chk("slave error", 32'h1, {31'h0, pm.err});
    wch(63, 16'h0);
    // Distribution into every area, then a zero word.
    wch(756, 16'h0003);
    for (int j = 0; j < 5; j++)
      op(2'd0, cst(rnd() | 1), opd(0, j, 0), oc, lo[j] + 3, 32'h5);
    op(2'd0, cst(0), opd(0, 4, 0), oc, 259, 32'h5);
    wch(63, 16'h0);
    // Offset limits, a non-decimal offset, area crossings and special channels.
    wch(756, 16'h0255);
    op(2'd0, cst(16'h5A5A), opd(0, 4, 256), oc, 767, 32'h5);
    wch(756, 16'h0256);
    op(2'd0, cst(16'h1234), opd(0, 4, 256), oc, 767, 32'h5);
    wch(756, 16'h000A);
    wch(266, 16'h7777);
    op(2'd0, cst(1), opd(0, 4, 0), oc, 266, 32'h5);
    wch(756, 16'h0001);
    wch(96, 16'h3C3C);
    op(2'd0, cst(2), opd(0, 1, 31), oc, 96, 32'h5);
    wch(61, 16'hBEEF);
    op(2'd0, cst(3), opd(0, 0, 60), oc, 61, 32'h5);
    op(2'd1, opd(0, 0, 60), oc, opd(0, 2, 5), 101, 32'h5);
    wch(63, 16'h0);
    // Extraction of a random word and of a zero word.
    wch(756, 16'h0010);
    wch(266, 16'(rnd()) | 16'h1);
    op(2'd1, opd(0, 4, 0), oc, opd(0, 2, 2), 98, 32'h5);
    pm.xfer(1'b0, ADDR_RESULT, 32'h0);
    chk("result", {16'h0, rm[98]}, pm.rdata);
    wch(266, 16'h0);
    op(2'd1, opd(0, 4, 0), oc, opd(0, 2, 2), 98, 32'h5);
    wch(63, 16'h0);
    // Indirect base through a pointer, then out-of-range and non-decimal pointers.
    wch(756, 16'h0000);
    wch(259, 16'h0020);
    op(2'd0, cst(16'h4321), opd(1, 4, 3), oc, 276, 32'h5);
    wch(259, 16'h0512);
    op(2'd0, cst(16'h1111), opd(1, 4, 3), oc, 276, 32'h5);
    wch(259, 16'h001F);
    op(2'd0, cst(16'h2222), opd(1, 4, 3), oc, 276, 32'h5);
    op(2'd0, opd(1, 4, 600), opd(0, 4, 3), oc, 259, 32'h5);
    // Bit copies with random bit numbers, bad controls and an undefined code.
    wch(286, 16'h0F0F);
    for (int j = 0; j < 6; j++)
    begin
      s = (j == 0) ? 15 : int'(rnd() % 16);
      d = (j == 0) ? 15 : int'(rnd() % 16);
      v = 16'(((d / 10) << 12) | ((d % 10) << 8) | ((s / 10) << 4) | (s % 10));
      op(2'd2, cst(rnd()), cst(v), dc, 286, 32'h5);
    end
    foreach (bad[k])
      op(2'd2, cst(16'hFFFF), cst(bad[k]), dc, 286, 32'h5);
    op(2'd3, oc, oc, dc, 286, 32'h5);
    // Condition low, then the interrupt masked, raised and cleared.
    pm.xfer(1'b0, ADDR_STATUS, 32'h0);
    op(2'd2, cst(16'hFFFF), cst(16'h0500), dc, 286, 32'h4);
    pm.xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("done", 32'h0, {31'h0, pm.rdata[ST_DONE]});
    pm.xfer(1'b1, ADDR_MASK, 32'h2);
    op(2'd2, cst(16'hFFFF), cst(16'h0500), dc, 286, 32'h5);
    chk("irq", 32'h0, {31'h0, irq});
    op(2'd3, oc, oc, dc, 286, 32'h5);
    chk("irq", 32'h1, {31'h0, irq});
    pm.xfer(1'b1, ADDR_MASK, 32'h1);
    pm.xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("done", 32'h1, {31'h0, pm.rdata[ST_DONE]});
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Periodic scan keeps rewriting the target while the condition holds.
    wch(756, 16'h0002);
    op(2'd0, cst(16'hA5C3), opd(0, 4, 40), oc, 298, 32'h7);
    wch(298, 16'h0);
    repeat (SCAN_CYCLES + 20) @(posedge clk);
    rm[298] = 16'hA5C3;
    chkch(298);
    pm.xfer(1'b1, ADDR_CTRL, 32'h0);
    wrap_up();
  end
endmodule // tb_top
